// ---- fes_pkg.sv ----
// package: constants shared by the flash erase sequencer ends
package fes_pkg;
    // ----------------------------------------
    // commands and unlock keys
    // ----------------------------------------
    localparam logic [7:0] FES_CMD_PAGE_ERASE = 8'h95;
    localparam logic [7:0] FES_CMD_MASS_ERASE = 8'h63;
    localparam logic [7:0] FES_KEY_FIRST = 8'h73;
    localparam logic [7:0] FES_KEY_SECOND = 8'h8C;
    localparam logic [7:0] FES_ERASED_BYTE = 8'hFF;
    // ----------------------------------------
    // array geometry and timing
    // ----------------------------------------
    localparam int FES_PAGE_BYTES = 512;
    localparam int FES_PAGE_AW = 9;
    localparam int FES_PAGES = 8;
    localparam int FES_PAGE_IDX_W = 3;
    localparam int FES_CLK_MHZ = 200;
    localparam int FES_ERASE_US = 10;
    localparam int FES_ERASE_CYC = FES_ERASE_US * FES_CLK_MHZ;
    // ----------------------------------------
    // status codes
    // ----------------------------------------
    localparam logic [1:0] FES_ST_LOCKED = 2'h0;
    localparam logic [1:0] FES_ST_HALF = 2'h1;
    localparam logic [1:0] FES_ST_UNLOCKED = 2'h2;
    localparam logic [1:0] FES_ST_BUSY = 2'h3;
endpackage

// ---- fes_if.sv ----
// interface: command link between host side and erase sequencer
`timescale 1ns/1ps
interface fes_if;
    logic cmd_valid;
    logic [7:0] cmd_data;
    logic cmd_from_debug;
    logic [2:0] page_sel;
    logic mass_enable;
    logic [1:0] status;
    logic busy;
    logic cpu_stall;
    logic done;
    logic protect_err;
    modport dev (input cmd_valid, input cmd_data, input cmd_from_debug, input page_sel, input mass_enable,
                 output status, output busy, output cpu_stall, output done, output protect_err);
    modport host (output cmd_valid, output cmd_data, output cmd_from_debug, output page_sel, output mass_enable,
                  input status, input busy, input cpu_stall, input done, input protect_err);
endinterface

// ---- fes_host.sv ----
// module: host end issuing unlock and erase sequences, polling status
`timescale 1ns/1ps
module fes_host
    import fes_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic start_in,
    input wire logic mass_in,
    input wire logic debug_in,
    input wire logic [2:0] page_in,
    output logic ready_out,
    output logic done_out,
    fes_if.host link
);
    typedef enum {FES_H_IDLE, FES_H_KEY1, FES_H_KEY2, FES_H_CMD, FES_H_POLL} fes_hstate_t;
    fes_hstate_t st_r, st_nxt;
    logic mass_r, mass_nxt, dbg_r, dbg_nxt, done_r, done_nxt;
    logic [2:0] page_r, page_nxt;

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        mass_nxt = mass_r;
        dbg_nxt = dbg_r;
        page_nxt = page_r;
        done_nxt = 1'b0;
        case (st_r)
            FES_H_IDLE:
            begin
                if (start_in)
                begin
                    st_nxt = FES_H_KEY1;
                    mass_nxt = mass_in;
                    // never upgrade a core request to debug: mass erase must be refused then
                    dbg_nxt = debug_in;
                    page_nxt = page_in;
                end
            end
            FES_H_KEY1: st_nxt = FES_H_KEY2;
            FES_H_KEY2: st_nxt = FES_H_CMD;
            FES_H_CMD: st_nxt = FES_H_POLL;
            FES_H_POLL:
            begin
                // poll status until the sequencer relocks
                if (link.status == FES_ST_LOCKED)
                begin
                    st_nxt = FES_H_IDLE;
                    done_nxt = 1'b1;
                end
            end
            default: st_nxt = FES_H_IDLE;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            st_r <= FES_H_IDLE;
            mass_r <= 1'b0;
            dbg_r <= 1'b0;
            page_r <= 3'h0;
            done_r <= 1'b0;
        end
        else if (ce_in)
        begin
            st_r <= st_nxt;
            mass_r <= mass_nxt;
            dbg_r <= dbg_nxt;
            page_r <= page_nxt;
            done_r <= done_nxt;
        end
    end

    // host programs no byte here, so the twice-per-erase limit holds trivially
    assign link.cmd_valid = ce_in && (st_r == FES_H_KEY1 || st_r == FES_H_KEY2 || st_r == FES_H_CMD);
    assign link.cmd_data = (st_r == FES_H_KEY1) ? FES_KEY_FIRST :
                           (st_r == FES_H_KEY2) ? FES_KEY_SECOND :
                           (mass_r ? FES_CMD_MASS_ERASE : FES_CMD_PAGE_ERASE);
    assign link.cmd_from_debug = dbg_r;
    assign link.page_sel = page_r;
    assign link.mass_enable = mass_r;
    assign ready_out = (st_r == FES_H_IDLE);
    assign done_out = done_r;
endmodule

// ---- fes_device.sv ----
// module: flash erase sequencer with unlock, page/mass erase and bypass
// Functional notes
// - host programs each byte at most twice
// - erase one 512-byte page to FFH
// - page from select, only if unprotected
// - unlocked plus page, 95h starts page erase
// - stall cpu during erase, peripherals run
// - debug port polls status for page erase
// - relock after page erase completes
// - mass erase only via debug port
// - unlocked plus enabled, 63H starts mass erase
// - poll during mass erase, then relock
// - bypass routes flash controls to pins
// - bypass keeps page erase, rows external
// - row programming via bypass for gangs
`timescale 1ns/1ps
module fes_device
    import fes_pkg::*;
#(
    parameter int PAGES = FES_PAGES,
    parameter int ERASE_CYC = FES_ERASE_CYC
)
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [PAGES-1:0] protect_in,
    input wire logic bypass_in,
    input wire logic pin_erase_in,
    input wire logic [2:0] pin_page_in,
    input wire logic pin_prog_in,
    output logic pin_busy_out,
    output logic [PAGES-1:0] page_blank_out,
    output logic array_wr_out,
    output logic array_erase_out,
    output logic [2:0] array_page_out,
    output logic [7:0] array_fill_out,
    fes_if.dev link
);
    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    if (PAGES < 1 || PAGES > (1 << FES_PAGE_IDX_W))
    begin : g_bad_pages
        $error("fes_device: PAGES must fit the page index");
    end
    if (ERASE_CYC < 1)
    begin : g_bad_erase_cyc
        $error("fes_device: ERASE_CYC must be positive");
    end

    typedef enum {FES_LOCKED, FES_HALF, FES_UNLOCKED, FES_ERASE} fes_state_t;
    fes_state_t st_r, st_nxt;
    logic mass_r, mass_nxt, done_r, done_nxt, perr_r, perr_nxt;
    logic [2:0] page_r, page_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic [PAGES-1:0] blank_r, blank_nxt;
    // pin synchronisers, first stage read only by the second
    logic [4:0] pin_s1_r, pin_s2_r;
    logic pe_prev_r;
    logic p_erase, p_prog, p_erase_rise;
    logic [2:0] p_page;
    logic page_ok, unprot;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            pin_s1_r <= 5'h00;
            pin_s2_r <= 5'h00;
            pe_prev_r <= 1'b0;
        end
        else if (ce_in)
        begin
            pin_s1_r <= {pin_prog_in, pin_page_in, pin_erase_in};
            pin_s2_r <= pin_s1_r;
            pe_prev_r <= pin_s2_r[0];
        end
    end
    assign p_erase = pin_s2_r[0];
    assign p_page = pin_s2_r[3:1];
    assign p_prog = pin_s2_r[4];
    assign p_erase_rise = p_erase & ~pe_prev_r;

    assign page_ok = (32'(link.page_sel) < PAGES);
    assign unprot = page_ok && !protect_in[link.page_sel];

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        mass_nxt = mass_r;
        page_nxt = page_r;
        cnt_nxt = cnt_r;
        blank_nxt = blank_r;
        done_nxt = 1'b0;
        perr_nxt = perr_r;
        case (st_r)
            FES_LOCKED:
            begin
                // bypass skips the controller; pin erase still allowed
                if (bypass_in && p_erase_rise && 32'(p_page) < PAGES && !protect_in[p_page])
                begin
                    st_nxt = FES_ERASE;
                    mass_nxt = 1'b0;
                    page_nxt = p_page;
                    cnt_nxt = 32'(ERASE_CYC);
                end
                else if (link.cmd_valid && link.cmd_data == FES_KEY_FIRST && !bypass_in)
                    st_nxt = FES_HALF;
                // erase codes while locked are ignored
            end
            FES_HALF:
            begin
                if (link.cmd_valid)
                    st_nxt = (link.cmd_data == FES_KEY_SECOND) ? FES_UNLOCKED : FES_LOCKED;
            end
            FES_UNLOCKED:
            begin
                if (link.cmd_valid)
                begin
                    if (link.cmd_data == FES_CMD_PAGE_ERASE && unprot)
                    begin
                        st_nxt = FES_ERASE;
                        mass_nxt = 1'b0;
                        page_nxt = link.page_sel;
                        cnt_nxt = 32'(ERASE_CYC);
                        perr_nxt = 1'b0;
                    end
                    else if (link.cmd_data == FES_CMD_MASS_ERASE && link.mass_enable
                             && link.cmd_from_debug)
                    begin
                        st_nxt = FES_ERASE;
                        mass_nxt = 1'b1;
                        cnt_nxt = 32'(ERASE_CYC);
                        perr_nxt = 1'b0;
                    end
                    else
                    begin
                        // protected target or bad code: relock, array untouched
                        st_nxt = FES_LOCKED;
                        perr_nxt = (link.cmd_data == FES_CMD_PAGE_ERASE);
                    end
                end
            end
            FES_ERASE:
            begin
                if (cnt_r == 32'h1)
                begin
                    st_nxt = FES_LOCKED;
                    done_nxt = 1'b1;
                    if (mass_r)
                        blank_nxt = '1;
                    else
                        blank_nxt[page_r] = 1'b1;
                end
                else
                    cnt_nxt = cnt_r - 32'h1;
            end
            default: st_nxt = FES_LOCKED;
        endcase
        // external row programming dirties the page it targets
        if (bypass_in && p_prog && st_r != FES_ERASE && 32'(p_page) < PAGES)
            blank_nxt[p_page] = 1'b0;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            st_r <= FES_LOCKED;
            mass_r <= 1'b0;
            page_r <= 3'h0;
            cnt_r <= 32'h0;
            blank_r <= '0;
            done_r <= 1'b0;
            perr_r <= 1'b0;
        end
        else if (ce_in)
        begin
            st_r <= st_nxt;
            mass_r <= mass_nxt;
            page_r <= page_nxt;
            cnt_r <= cnt_nxt;
            blank_r <= blank_nxt;
            done_r <= done_nxt;
            perr_r <= perr_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_comb
    begin
        case (st_r)
            FES_LOCKED: link.status = FES_ST_LOCKED;
            FES_HALF: link.status = FES_ST_HALF;
            FES_UNLOCKED: link.status = FES_ST_UNLOCKED;
            FES_ERASE: link.status = FES_ST_BUSY;
            default: link.status = FES_ST_LOCKED;
        endcase
    end
    assign link.busy = (st_r == FES_ERASE);
    // stall only the core; clock and peripherals keep running
    assign link.cpu_stall = (st_r == FES_ERASE);
    assign link.done = done_r;
    assign link.protect_err = perr_r;
    assign pin_busy_out = (st_r == FES_ERASE);
    assign page_blank_out = blank_r;
    // in bypass, row writes go from the two-stage synchronised pins to the array, except during erase
    assign array_wr_out = bypass_in & p_prog & (st_r != FES_ERASE);
    assign array_erase_out = (st_r == FES_ERASE);
    assign array_page_out = (st_r == FES_ERASE) ? page_r : p_page;
    assign array_fill_out = FES_ERASED_BYTE;
endmodule

// ---- fes_chk.sv ----
// checker: link assertions for the erase sequencer
`timescale 1ns/1ps
module fes_chk
    import fes_pkg::*;
#(
    parameter int ERASE_CYC = FES_ERASE_CYC
)
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_from_debug,
    input wire logic mass_enable,
    input wire logic [1:0] status,
    input wire logic busy,
    input wire logic cpu_stall,
    input wire logic done,
    input wire logic protect_err
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // ----
    // helper: busy length, too long for a repetition
    // ----
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic unl;
    assign unl = cmd_valid && status == FES_ST_UNLOCKED;
    always_comb cnt_nxt = busy ? cnt_r + 16'h1 : 16'h0;
    always_ff @(posedge clk_in) cnt_r <= rst_in ? 16'h0 : cnt_nxt;
    property p_stall; cpu_stall == busy; endproperty
    a_stall: assert property (p_stall) else $error("stall differs from busy");
    property p_len; $fell(busy) |-> $past(cnt_r) == ERASE_CYC - 1; endproperty
    a_len: assert property (p_len) else $error("erase length wrong");
    property p_relock; $fell(busy) |-> status == FES_ST_LOCKED; endproperty
    a_relock: assert property (p_relock) else $error("no relock after erase");
    property p_done; $fell(busy) |-> ##[0:1] done ##1 !done; endproperty
    a_done: assert property (p_done) else $error("done pulse wrong");
    property p_poll; busy |-> status == FES_ST_BUSY; endproperty
    a_poll: assert property (p_poll) else $error("status not busy");
    property p_page; unl && cmd_data == FES_CMD_PAGE_ERASE |=> busy || protect_err; endproperty
    a_page: assert property (p_page) else $error("page erase not started");
    property p_mass_ok; unl && cmd_data == FES_CMD_MASS_ERASE && cmd_from_debug && mass_enable |=> busy; endproperty
    a_mass_ok: assert property (p_mass_ok) else $error("mass erase not started");
    property p_mass_no;
        unl && cmd_data == FES_CMD_MASS_ERASE && !(cmd_from_debug && mass_enable) |=> !busy && status == FES_ST_LOCKED;
    endproperty
    a_mass_no: assert property (p_mass_no) else $error("mass erase not refused");
    property p_prot; $rose(protect_err) |-> !busy && status == FES_ST_LOCKED; endproperty
    a_prot: assert property (p_prot) else $error("refused erase ran");
    c_busy: cover property ($rose(busy));
    c_prot: cover property ($rose(protect_err));
    c_mass: cover property (unl && cmd_data == FES_CMD_MASS_ERASE);
endmodule

// ---- tb.sv ----
// testbench: host and sequencer joined over the link
`timescale 1ns/1ps
module tb;
    import fes_pkg::*;
    localparam int ECYC = 4;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic start_in = 1'b0;
    logic mass_in = 1'b0;
    logic debug_in = 1'b0;
    logic [2:0] page_in = 3'h0;
    logic bypass_in = 1'b0;
    logic pin_erase_in = 1'b0;
    logic pin_prog_in = 1'b0;
    logic ready_out, done_out, pin_busy_out, array_wr_out, array_erase_out;
    logic [7:0] page_blank_out, array_fill_out;
    logic [2:0] array_page_out;
    int num_errors = 0;
    int checks = 0;
    fes_if link ();
    fes_host u_fes_host (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .start_in(start_in), .mass_in(mass_in),
        .debug_in(debug_in), .page_in(page_in), .ready_out(ready_out), .done_out(done_out), .link(link.host));
    fes_device #(.ERASE_CYC(ECYC)) u_fes_device (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1),
        .protect_in(8'h20), .bypass_in(bypass_in), .pin_erase_in(pin_erase_in), .pin_page_in(3'h1),
        .pin_prog_in(pin_prog_in), .pin_busy_out(pin_busy_out), .page_blank_out(page_blank_out),
        .array_wr_out(array_wr_out), .array_erase_out(array_erase_out), .array_page_out(array_page_out),
        .array_fill_out(array_fill_out), .link(link.dev));
    fes_chk #(.ERASE_CYC(ECYC)) u_fes_chk (.clk_in(clk_in), .rst_in(rst_in), .cmd_valid(link.cmd_valid),
        .cmd_data(link.cmd_data), .cmd_from_debug(link.cmd_from_debug), .mass_enable(link.mass_enable),
        .status(link.status), .busy(link.busy), .cpu_stall(link.cpu_stall), .done(link.done),
        .protect_err(link.protect_err));
    initial forever #2.5 clk_in = ~clk_in;
    // ----
    // tasks
    // ----
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("errors=%0d checks=%0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // waits on host done under a bound; stall seen on every busy cycle
    task automatic erase(input logic m, input logic d, input logic [2:0] pg);
        repeat (2) @(posedge clk_in);
        start_in <= 1'b1;
        mass_in <= m;
        debug_in <= d;
        page_in <= pg;
        @(posedge clk_in);
        start_in <= 1'b0;
        for (int n = 0; n < 60; n++)
        begin
            @(posedge clk_in);
            #1;
            if (link.busy === 1'b1)
                check(8'(link.cpu_stall), 8'h1);
            if (done_out === 1'b1)
                break;
        end
        check(8'(done_out), 8'h1);
        check(8'(link.status), 8'h0);
        check(8'(ready_out), 8'h1);
        $display("test erase m=%0d d=%0d page=%0d done", m, d, pg);
    endtask
    // ----
    // tests
    // ----
    initial
    begin
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        bypass_in <= 1'b1;
        pin_prog_in <= 1'b1;
        @(posedge clk_in);
        // single-cycle row write: each byte programmed once before its erase
        pin_prog_in <= 1'b0;
        @(posedge clk_in);
        #1;
        check(8'(array_wr_out), 8'h1);
        @(posedge clk_in);
        #1;
        check(8'(array_wr_out), 8'h0);
        @(posedge clk_in);
        pin_erase_in <= 1'b1;
        for (int n = 0; n < 20 && pin_busy_out !== 1'b1; n++)
        begin
            @(posedge clk_in);
            #1;
        end
        check(8'(array_erase_out), 8'h1);
        check(8'(array_page_out), 8'h1);
        check(array_fill_out, FES_ERASED_BYTE);
        for (int n = 0; n < 20 && pin_busy_out !== 1'b0; n++)
        begin
            @(posedge clk_in);
            #1;
        end
        @(posedge clk_in);
        pin_erase_in <= 1'b0;
        bypass_in <= 1'b0;
        #1;
        check(page_blank_out, 8'h02);
        $display("test bypass done");
        erase(1'b0, 1'b0, 3'h2);
        check(page_blank_out, 8'h06);
        check(8'(link.protect_err), 8'h0);
        erase(1'b0, 1'b0, 3'h5);
        check(page_blank_out, 8'h06);
        check(8'(link.protect_err), 8'h1);
        erase(1'b1, 1'b0, 3'h0);
        check(page_blank_out, 8'h06);
        erase(1'b1, 1'b1, 3'h0);
        check(page_blank_out, 8'hFF);
        finish_test();
    end
    initial
    begin
        #20000;
        num_errors++;
        finish_test();
    end
endmodule
